// ==== design/usb_reset_detect_hs_handshake.sv ====
// USB bus reset detection and device side high speed detection handshake
//
// Contract
// - High speed idle 3 ms switches transceiver and termination to full speed.
// - Sample line 100-875 us after changeover; SE0 flags reset, J flags suspend.
// - Idle changeover happens no earlier than 3.0 ms, no later than 3.125 ms.
// - Interrupt low as reset or chirp flag sets, if both enables are set.
// - Full speed SE0 held 2.5 us sets the bus reset flag.
// - Handshake starts with full speed transceiver and termination selected.
// - Start chirp forces raw operating mode and all zero transmit data.
// - Chirp K sent on high speed transceiver before 6.0 ms after reset start.
// - Chirp K lasts 66,000 cycles at 60 MHz, ends before 7.0 ms.
// - After chirp K, wait for downstream chirps, starting within 100 us.
// - No downstream chirp within 1.0-2.5 ms: fall back to full speed, complete.
// - Six alternating downstream chirps: high speed termination, complete handshake.
//
// Local design decisions: the APB interface to the registers and the register offsets.
`timescale 1ns/1ps
module usb_reset_detect_hs_handshake
   import usb_link_pkg::*;
#(
   parameter int IDLE_CYC    = IDLE_CYC_DEF,
   parameter int CHIRP_K_CYC = CHIRP_K_CYC_DEF,
   parameter int WAIT_FS_CYC = WAIT_FS_CYC_DEF
) (
   input  logic        CLK,
   input  logic        RST_N,
   input  logic        PSEL,
   input  logic        PENABLE,
   input  logic        PWRITE,
   input  logic [7:0]  PADDR,
   input  logic [31:0] PWDATA,
   output logic [31:0] PRDATA,
   output logic        PREADY,
   output logic        PSLVERR,
   input  logic [1:0]  LINE_STATE,
   input  logic        BUS_ACTIVITY,
   output xcvr_ctrl_t  XCVR_CTRL,
   output logic        ACTIVATE_ALL_CLK,
   output logic        INTERRUPT_OUT_N
);

   logic [1:0]       ls_s1_q;
   logic [1:0]       ls_s2_q;
   link_state_t      state_q;
   logic [CNT_W-1:0] cnt_q;
   logic [2:0]       chirp_cnt_q;
   logic [1:0]       last_chirp_q;
   xcvr_ctrl_t       xcvr_q;
   logic             fs_result_q;
   logic             start_chirp_q;
   logic             det_dis_q;
   logic             act_all_q;
   logic [2:0]       stat_q;
   logic [2:0]       stat_d;
   logic [2:0]       ien_q;
   logic             top_ien_q;
   logic [31:0]      prdata_q;
   logic             set_reset;
   logic             set_susp;
   logic             set_chirp;
   logic             hs_active;
   logic             se0;
   logic             chirp_seen;
   logic             wr;
   logic             addr_ok;

   // Line state synchroniser
   always_ff @(posedge CLK) begin
      if (!RST_N) begin
         ls_s1_q <= LS_SE0;
         ls_s2_q <= LS_SE0;
      end else begin
         ls_s1_q <= LINE_STATE;
         ls_s2_q <= ls_s1_q;
      end
   end

   // Line decodes
   assign se0        = (ls_s2_q == LS_SE0);
   assign hs_active  = BUS_ACTIVITY || (ls_s2_q == LS_J);
   assign chirp_seen = ((ls_s2_q == LS_K) || (ls_s2_q == LS_J)) && (ls_s2_q != last_chirp_q);

   // Event strobes from the link state machine
   assign set_reset = (!det_dis_q && state_q == ST_FS && se0 && cnt_q == CNT_W'(SE0_CYC - 1)) ||
                      (state_q == ST_HS_SAMPLE && cnt_q == CNT_W'(SAMPLE_CYC - 1) && se0);
   assign set_susp  = state_q == ST_HS_SAMPLE && cnt_q == CNT_W'(SAMPLE_CYC - 1) && !se0;
   assign set_chirp = state_q == ST_WAIT_CHIRP &&
                      ((cnt_q == CNT_W'(WAIT_FS_CYC - 1) && !chirp_seen) ||
                       (chirp_seen && chirp_cnt_q == 3'(CHIRP_PAIRS - 1)));

   // Link state machine, duration counter and transceiver controls
   always_ff @(posedge CLK) begin
      if (!RST_N) begin
         state_q      <= ST_FS;
         cnt_q        <= '0;
         chirp_cnt_q  <= 3'h0;
         last_chirp_q <= LS_SE0;
         xcvr_q       <= XCVR_RST;
         fs_result_q  <= 1'b1;
      end else begin
         case (state_q)
            ST_FS: begin
               if (start_chirp_q) begin
                  // Raw mode, zero data, high speed transceiver drives chirp K
                  state_q          <= ST_CHIRP_K;
                  cnt_q            <= '0;
                  xcvr_q.op_mode   <= OPM_RAW;
                  xcvr_q.tx_data   <= 8'h00;
                  xcvr_q.speed_sel <= 1'b0;
                  xcvr_q.tx_valid  <= 1'b1;
               end else if (!se0) begin
                  cnt_q <= '0;
               end else if (cnt_q != CNT_W'(SE0_CYC)) begin
                  cnt_q <= cnt_q + 1'b1;
               end
            end
            ST_HS: begin
               if (hs_active || det_dis_q) begin
                  cnt_q <= '0;
               end else if (cnt_q == CNT_W'(IDLE_CYC - 1)) begin
                  state_q          <= ST_HS_SAMPLE;
                  cnt_q            <= '0;
                  xcvr_q.speed_sel <= 1'b1;
                  xcvr_q.term_sel  <= 1'b1;
               end else begin
                  cnt_q <= cnt_q + 1'b1;
               end
            end
            ST_HS_SAMPLE: begin
               if (cnt_q == CNT_W'(SAMPLE_CYC - 1)) begin
                  state_q <= ST_FS;
                  cnt_q   <= '0;
               end else begin
                  cnt_q <= cnt_q + 1'b1;
               end
            end
            ST_CHIRP_K: begin
               if (cnt_q == CNT_W'(CHIRP_K_CYC - 1)) begin
                  state_q         <= ST_WAIT_CHIRP;
                  cnt_q           <= '0;
                  xcvr_q.tx_valid <= 1'b0;
                  chirp_cnt_q     <= 3'h0;
                  last_chirp_q    <= LS_SE0;
               end else begin
                  cnt_q <= cnt_q + 1'b1;
               end
            end
            ST_WAIT_CHIRP: begin
               if (chirp_seen) begin
                  cnt_q        <= '0;
                  last_chirp_q <= ls_s2_q;
                  chirp_cnt_q  <= chirp_cnt_q + 1'b1;
                  if (chirp_cnt_q == 3'(CHIRP_PAIRS - 1)) begin
                     state_q         <= ST_HS;
                     xcvr_q.term_sel <= 1'b0;
                     xcvr_q.op_mode  <= OPM_NORMAL;
                     fs_result_q     <= 1'b0;
                  end
               end else if (cnt_q == CNT_W'(WAIT_FS_CYC - 1)) begin
                  state_q          <= ST_FS;
                  cnt_q            <= '0;
                  xcvr_q.speed_sel <= 1'b1;
                  xcvr_q.op_mode   <= OPM_NORMAL;
                  fs_result_q      <= 1'b1;
               end else begin
                  cnt_q <= cnt_q + 1'b1;
               end
            end
            default: begin
               state_q <= ST_FS;
               xcvr_q  <= XCVR_RST;
            end
         endcase
      end
   end

   // APB decode
   assign wr      = PSEL && PENABLE && PWRITE;
   assign addr_ok = PADDR == OFS_CTRL || PADDR == OFS_STAT || PADDR == OFS_IEN ||
                    PADDR == OFS_TOP_IEN || PADDR == OFS_XCVR;

   // Control bits, start chirp cleared by hardware on completion
   always_ff @(posedge CLK) begin
      if (!RST_N) begin
         start_chirp_q <= CTRL_RST[B_START];
         det_dis_q     <= CTRL_RST[B_DIS_DET];
         act_all_q     <= CTRL_RST[B_ACT_ALL];
      end else begin
         if (wr && PADDR == OFS_CTRL) begin
            start_chirp_q <= PWDATA[B_START];
            det_dis_q     <= PWDATA[B_DIS_DET];
            act_all_q     <= PWDATA[B_ACT_ALL];
         end
         if (set_chirp) begin
            start_chirp_q <= 1'b0;
         end
      end
   end

   // Sticky status, set wins over write one to clear
   always_comb begin
      stat_d = stat_q;
      if (wr && PADDR == OFS_STAT) begin
         stat_d = stat_q & ~PWDATA[2:0];
      end
      stat_d[B_RESET] = stat_d[B_RESET] | set_reset;
      stat_d[B_SUSP]  = stat_d[B_SUSP] | set_susp;
      stat_d[B_CHIRP] = stat_d[B_CHIRP] | set_chirp;
   end

   // Status and enable registers
   always_ff @(posedge CLK) begin
      if (!RST_N) begin
         stat_q    <= STAT_RST;
         ien_q     <= 3'h0;
         top_ien_q <= 1'b0;
      end else begin
         stat_q <= stat_d;
         if (wr && PADDR == OFS_IEN) begin
            ien_q <= PWDATA[2:0];
         end
         if (wr && PADDR == OFS_TOP_IEN) begin
            top_ien_q <= PWDATA[0];
         end
      end
   end

   // Read data captured in the setup phase
   always_ff @(posedge CLK) begin
      if (!RST_N) begin
         prdata_q <= 32'h0000_0000;
      end else if (PSEL && !PENABLE) begin
         case (PADDR)
            OFS_CTRL:    prdata_q <= {29'h0000_0000, act_all_q, det_dis_q, start_chirp_q};
            OFS_STAT:    prdata_q <= {29'h0000_0000, stat_q};
            OFS_IEN:     prdata_q <= {29'h0000_0000, ien_q};
            OFS_TOP_IEN: prdata_q <= {31'h0000_0000, top_ien_q};
            OFS_XCVR:    prdata_q <= {25'h0000_0000, ls_s2_q, fs_result_q, xcvr_q.op_mode,
                                      xcvr_q.term_sel, xcvr_q.speed_sel};
            default:     prdata_q <= 32'h0000_0000;
         endcase
      end
   end

   // Outputs
   assign PRDATA           = prdata_q;
   assign PREADY           = 1'b1;
   assign PSLVERR          = PSEL && PENABLE && !addr_ok;
   assign XCVR_CTRL        = xcvr_q;
   assign ACTIVATE_ALL_CLK = act_all_q;
   assign INTERRUPT_OUT_N  = !(top_ien_q && ((stat_q & ien_q) != 3'h0));

   // Checks
   property p_int_on_flag;
      @(posedge CLK) disable iff (!RST_N)
      (set_reset && ien_q[B_RESET] && top_ien_q) |=> !INTERRUPT_OUT_N;
   endproperty
   a_int_on_flag: assert property (p_int_on_flag) else $error("Interrupt missing on reset flag");

   property p_int_chirp;
      @(posedge CLK) disable iff (!RST_N)
      (set_chirp && ien_q[B_CHIRP] && top_ien_q) |=> !INTERRUPT_OUT_N && stat_q[B_CHIRP];
   endproperty
   a_int_chirp: assert property (p_int_chirp) else $error("Interrupt missing on chirp flag");

   property p_fs_reset;
      @(posedge CLK) disable iff (!RST_N)
      (state_q == ST_FS && !det_dis_q && !start_chirp_q && se0 && cnt_q == CNT_W'(SE0_CYC - 1))
         |=> stat_q[B_RESET];
   endproperty
   a_fs_reset: assert property (p_fs_reset) else $error("Full speed SE0 did not flag reset");

   property p_hs_changeover;
      @(posedge CLK) disable iff (!RST_N)
      (state_q == ST_HS && $past(state_q) == ST_HS) |-> !xcvr_q.speed_sel && !xcvr_q.term_sel;
   endproperty
   a_hs_changeover: assert property (p_hs_changeover) else $error("Early changeover in high speed");

   property p_idle_fs;
      @(posedge CLK) disable iff (!RST_N)
      (state_q == ST_HS && !hs_active && !det_dis_q && cnt_q == CNT_W'(IDLE_CYC - 1))
         |=> xcvr_q.speed_sel && xcvr_q.term_sel && state_q == ST_HS_SAMPLE && cnt_q == '0;
   endproperty
   a_idle_fs: assert property (p_idle_fs) else $error("Idle changeover wrong");

   property p_sample;
      @(posedge CLK) disable iff (!RST_N)
      (state_q == ST_HS_SAMPLE && cnt_q == CNT_W'(SAMPLE_CYC - 1)) |=> (stat_q[B_RESET] || stat_q[B_SUSP]);
   endproperty
   a_sample: assert property (p_sample) else $error("Line sample set no flag");

   property p_chirp_k;
      @(posedge CLK) disable iff (!RST_N)
      state_q == ST_CHIRP_K |-> xcvr_q.op_mode == OPM_RAW && xcvr_q.tx_data == 8'h00 &&
                                xcvr_q.tx_valid && !xcvr_q.speed_sel && xcvr_q.term_sel;
   endproperty
   a_chirp_k: assert property (p_chirp_k) else $error("Chirp K drive wrong");

   property p_chirp_len;
      @(posedge CLK) disable iff (!RST_N)
      $fell(xcvr_q.tx_valid) |-> $past(cnt_q) == CNT_W'(CHIRP_K_CYC - 1) && state_q == ST_WAIT_CHIRP;
   endproperty
   a_chirp_len: assert property (p_chirp_len) else $error("Chirp K length wrong");

   property p_fallback;
      @(posedge CLK) disable iff (!RST_N)
      (state_q == ST_WAIT_CHIRP && !chirp_seen && cnt_q == CNT_W'(WAIT_FS_CYC - 1))
         |=> xcvr_q.speed_sel && fs_result_q && !start_chirp_q && stat_q[B_CHIRP];
   endproperty
   a_fallback: assert property (p_fallback) else $error("Full speed fallback wrong");

   property p_hs_done;
      @(posedge CLK) disable iff (!RST_N)
      (state_q == ST_WAIT_CHIRP && chirp_seen && chirp_cnt_q == 3'(CHIRP_PAIRS - 1))
         |=> !xcvr_q.term_sel && !fs_result_q && !start_chirp_q && stat_q[B_CHIRP] && state_q == ST_HS;
   endproperty
   a_hs_done: assert property (p_hs_done) else $error("High speed completion wrong");

   c_fs_reset: cover property (@(posedge CLK) disable iff (!RST_N) $rose(stat_q[B_RESET]));
   c_fallback: cover property (@(posedge CLK) disable iff (!RST_N) state_q == ST_WAIT_CHIRP ##1 state_q == ST_FS);
   c_hs_done:  cover property (@(posedge CLK) disable iff (!RST_N) state_q == ST_WAIT_CHIRP ##1 state_q == ST_HS);
   c_suspend:  cover property (@(posedge CLK) disable iff (!RST_N) $rose(stat_q[B_SUSP]));

endmodule

// ==== common/usb_link_pkg.sv ====
// Shared constants, register map and types for the USB reset detect and chirp block
package usb_link_pkg;
   // Clock rate and time conversion
   localparam int CLK_MHZ         = 40;
   localparam int REF_MHZ         = 60;       // Rate at which the chirp K cycle count is given
   localparam int IDLE_MIN_NS     = 3000000;  // 3.0 ms idle before changeover
   localparam int IDLE_MAX_NS     = 3125000;  // 3.125 ms latest changeover
   localparam int SAMPLE_MIN_NS   = 100000;   // 100 us after changeover
   localparam int SAMPLE_MAX_NS   = 875000;   // 875 us after changeover
   localparam int SE0_FS_NS       = 2500;     // 2.5 us SE0 in full speed
   localparam int CHIRP_K_REF_CYC = 66000;    // Chirp K length at REF_MHZ
   localparam int WAIT_FS_MIN_NS  = 1000000;  // 1.0 ms without downstream chirp
   localparam int WAIT_FS_MAX_NS  = 2500000;  // 2.5 ms latest fallback
   localparam int CHIRP_PAIRS     = 6;        // Alternating chirps needed

   // Least time in ns to whole cycles, rounded up, at least one
   function automatic int cyc_up(input int ns);
      int c;
      c = (ns * CLK_MHZ + 999) / 1000;
      return (c < 1) ? 1 : c;
   endfunction

   localparam int IDLE_CYC_DEF    = cyc_up(IDLE_MIN_NS);
   localparam int SAMPLE_CYC      = cyc_up(SAMPLE_MIN_NS);
   localparam int SE0_CYC         = cyc_up(SE0_FS_NS);
   localparam int CHIRP_K_CYC_DEF = (CHIRP_K_REF_CYC * CLK_MHZ + REF_MHZ - 1) / REF_MHZ;
   localparam int WAIT_FS_CYC_DEF = cyc_up(WAIT_FS_MIN_NS);
   localparam int CNT_W           = 18;

   // Register byte offsets
   localparam logic [7:0] OFS_CTRL    = 8'h00;
   localparam logic [7:0] OFS_STAT    = 8'h04;
   localparam logic [7:0] OFS_IEN     = 8'h08;
   localparam logic [7:0] OFS_TOP_IEN = 8'h0C;
   localparam logic [7:0] OFS_XCVR    = 8'h10;

   // Field positions
   localparam int B_START   = 0;
   localparam int B_DIS_DET = 1;
   localparam int B_ACT_ALL = 2;
   localparam int B_RESET   = 0;
   localparam int B_CHIRP   = 1;
   localparam int B_SUSP    = 2;

   // Line state and operating mode codes
   localparam logic [1:0] LS_SE0     = 2'h0;
   localparam logic [1:0] LS_J       = 2'h1;
   localparam logic [1:0] LS_K       = 2'h2;
   localparam logic [1:0] OPM_NORMAL = 2'h0;
   localparam logic [1:0] OPM_RAW    = 2'h2;

   // Reset values
   localparam logic [2:0] CTRL_RST = 3'h0;
   localparam logic [2:0] STAT_RST = 3'h0;

   typedef enum logic [2:0] {ST_FS, ST_HS, ST_HS_SAMPLE, ST_CHIRP_K, ST_WAIT_CHIRP} link_state_t;

   typedef struct packed {
      logic       speed_sel;  // 1 = full speed
      logic       term_sel;   // 1 = full speed termination
      logic [1:0] op_mode;
      logic       tx_valid;
      logic [7:0] tx_data;
   } xcvr_ctrl_t;

   localparam xcvr_ctrl_t XCVR_RST = '{speed_sel: 1'b1, term_sel: 1'b1, op_mode: OPM_NORMAL,
                                       tx_valid: 1'b0, tx_data: 8'h00};
endpackage

// ==== tb/usb_host_model.sv ====
// Downstream port model: bus reset, idle J and the K/J chirp train
`timescale 1ns/1ps
module usb_host_model
   import usb_link_pkg::*;
#(
   parameter int CHIRP_LEN = 20,
   parameter int WTDCH     = 5
) (
   input  wire logic       clk,
   input  wire xcvr_ctrl_t xcvr,
   input  wire logic       hs_capable,
   input  wire logic       reset_req,
   output logic [1:0]      line_state
);
   logic tx_q = 1'b0;
   int   cnt  = 0;

   // Start the chirp train shortly after the device chirp ends
   always @(posedge clk) begin
      tx_q <= xcvr.tx_valid;
      if (tx_q && !xcvr.tx_valid && hs_capable)
         cnt <= 1;
      else if (cnt != 0 && cnt < WTDCH + 6 * CHIRP_LEN)
         cnt <= cnt + 1;
      else
         cnt <= 0;
   end

   // Line: alternating chirps, else reset SE0, else idle J
   always_comb begin
      if (cnt > WTDCH)
         line_state = (((cnt - WTDCH - 1) / CHIRP_LEN) % 2 == 0) ? LS_K : LS_J;
      else if (reset_req)
         line_state = LS_SE0;
      else
         line_state = LS_J;
   end
endmodule

// ==== tb/testbench.sv ====
// Self-checking bench for the USB reset detect and chirp handshake block
`timescale 1ns/1ps
module testbench
   import usb_link_pkg::*;
();
   localparam int IC = 50;
   localparam int CK = 40;
   localparam int WF = 60;
   localparam int CL = 20;
   logic        CLK          = 1'b0;
   logic        RST_N        = 1'b0;
   logic        PSEL         = 1'b0;
   logic        PENABLE      = 1'b0;
   logic        PWRITE       = 1'b0;
   logic [7:0]  PADDR        = 8'h00;
   logic [31:0] PWDATA       = 32'h0000_0000;
   logic        BUS_ACTIVITY = 1'b0;
   logic        hs_capable   = 1'b0;
   logic        reset_req    = 1'b0;
   logic [31:0] PRDATA;
   logic        PREADY;
   logic        PSLVERR;
   logic [1:0]  LINE_STATE;
   xcvr_ctrl_t  XCVR_CTRL;
   logic        ACTIVATE_ALL_CLK;
   logic        INTERRUPT_OUT_N;
   int          n_errors     = 0;
   int          n_tests      = 0;
   int          seed         = 32'he0e6;
   int          n;
   int          k;
   logic [31:0] rd;
   logic        err;

   // Clock
   always #12.5 CLK = ~CLK;

   usb_reset_detect_hs_handshake #(.IDLE_CYC(IC), .CHIRP_K_CYC(CK), .WAIT_FS_CYC(WF)) uut (
      .CLK(CLK), .RST_N(RST_N), .PSEL(PSEL), .PENABLE(PENABLE), .PWRITE(PWRITE), .PADDR(PADDR),
      .PWDATA(PWDATA), .PRDATA(PRDATA), .PREADY(PREADY), .PSLVERR(PSLVERR), .LINE_STATE(LINE_STATE),
      .BUS_ACTIVITY(BUS_ACTIVITY), .XCVR_CTRL(XCVR_CTRL), .ACTIVATE_ALL_CLK(ACTIVATE_ALL_CLK),
      .INTERRUPT_OUT_N(INTERRUPT_OUT_N));

   usb_host_model #(.CHIRP_LEN(CL), .WTDCH(5)) host (
      .clk(CLK), .xcvr(XCVR_CTRL), .hs_capable(hs_capable), .reset_req(reset_req), .line_state(LINE_STATE));

   task automatic chk(input logic [31:0] seen, input logic [31:0] exp, input string name);
      n_tests++;
      if (seen !== exp) begin
         n_errors++;
         $display("MISMATCH %s expected %h seen %h", name, exp, seen);
      end
   endtask

   // One APB transfer, then an idle cycle
   task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
      PSEL   <= 1'b1;
      PWRITE <= wr;
      PADDR  <= a;
      PWDATA <= wd;
      @(posedge CLK);
      PENABLE <= 1'b1;
      do begin
         @(posedge CLK);
      end while (PREADY !== 1'b1);
      rd  = PRDATA;
      err = PSLVERR;
      PSEL    <= 1'b0;
      PENABLE <= 1'b0;
      @(posedge CLK);
   endtask

   task automatic rchk(input logic [7:0] a, input logic [31:0] exp, input string name);
      apb(1'b0, a, 32'h0000_0000);
      chk(rd, exp, name);
   endtask

   // Expected transceiver status word
   function automatic logic [31:0] xexp(logic sp, logic tm, logic [1:0] om, logic fr, logic [1:0] ls);
      return {25'h0, ls, fr, om, tm, sp};
   endfunction

   task automatic final_report;
      $display("checks %0d mismatches %0d", n_tests, n_errors);
      if (n_errors == 0 && n_tests > 0)
         $display("bench passed");
      else
         $display("bench failed");
      $finish;
   endtask

   // Watchdog
   initial begin
      repeat (40000) @(posedge CLK);
      n_errors++;
      final_report();
   end

   // Main sequence
   initial begin
      repeat (5) @(posedge CLK);
      RST_N <= 1'b1;
      @(posedge CLK);
      rchk(OFS_CTRL, {29'h0, CTRL_RST}, "ctrl reset");
      rchk(OFS_STAT, {29'h0, STAT_RST}, "stat reset");
      rchk(OFS_XCVR, xexp(1, 1, OPM_NORMAL, 1, LS_J), "xcvr reset");
      apb(1'b1, OFS_XCVR, 32'h0000_0000);
      rchk(OFS_XCVR, xexp(1, 1, OPM_NORMAL, 1, LS_J), "xcvr read only");
      rchk(8'h14, 32'h0000_0000, "unmapped data");
      chk(err, 1, "unmapped error");
      for (int i = 0; i < 4; i++) begin
         k = $random(seed);
         apb(1'b1, OFS_IEN, 32'(k));
         rchk(OFS_IEN, 32'(k) & 32'h0000_0007, "ien readback");
      end
      $display("register test done");
      apb(1'b1, OFS_IEN, 32'h0000_0007);
      apb(1'b1, OFS_TOP_IEN, 32'h0000_0001);
      k = 20 + ($unsigned($random(seed)) % 70);
      reset_req <= 1'b1;
      repeat (k) @(posedge CLK);
      reset_req <= 1'b0;
      repeat (4) @(posedge CLK);
      rchk(OFS_STAT, 32'h0000_0000, "short se0");
      reset_req <= 1'b1;
      n = 0;
      while (INTERRUPT_OUT_N !== 1'b0 && n < 500) begin
         @(negedge CLK);
         n++;
      end
      chk(n >= SE0_CYC && n <= SE0_CYC + 6, 1, "se0 time");
      @(posedge CLK);
      rchk(OFS_STAT, 32'h0000_0001, "fs reset flag");
      apb(1'b1, OFS_IEN, 32'h0000_0006);
      chk(INTERRUPT_OUT_N, 1, "masked irq");
      apb(1'b1, OFS_IEN, 32'h0000_0007);
      chk(INTERRUPT_OUT_N, 0, "unmasked irq");
      apb(1'b1, OFS_TOP_IEN, 32'h0000_0000);
      chk(INTERRUPT_OUT_N, 1, "group masked irq");
      apb(1'b1, OFS_TOP_IEN, 32'h0000_0001);
      apb(1'b1, OFS_STAT, 32'h0000_0001);
      chk(INTERRUPT_OUT_N, 1, "irq cleared");
      $display("fs reset test done");
      // Handshake: plain full speed host, then high speed host ending in reset or suspend
      for (int m = 0; m < 3; m++) begin
         hs_capable <= (m != 0);
         reset_req  <= 1'b1;
         apb(1'b1, OFS_CTRL, 32'h0000_0006);
         chk(ACTIVATE_ALL_CLK, 1, "activate clocks");
         apb(1'b1, OFS_STAT, 32'h0000_0007);
         apb(1'b1, OFS_CTRL, 32'h0000_0007);
         @(negedge CLK);
         chk(XCVR_CTRL, {1'b0, 1'b1, OPM_RAW, 1'b1, 8'h00}, "chirp ctrl");
         n = 1;
         while (XCVR_CTRL.tx_valid === 1'b1 && n < 500) begin
            @(negedge CLK);
            n++;
         end
         chk(32'(n - 1), CK, "chirp length");
         n = 0;
         while (INTERRUPT_OUT_N !== 1'b0 && n < 1000) begin
            @(negedge CLK);
            n++;
         end
         @(posedge CLK);
         if (m == 0) begin
            chk(n >= WF && n <= WF + 6, 1, "fallback time");
            rchk(OFS_XCVR, xexp(1, 1, OPM_NORMAL, 1, LS_SE0), "fallback xcvr");
         end else begin
            chk(n <= 5 + 6 * CL + 6, 1, "chirp train time");
            rchk(OFS_XCVR, xexp(0, 0, OPM_NORMAL, 0, LS_J), "hs xcvr");
         end
         rchk(OFS_STAT, 32'h0000_0002, "chirp complete");
         rchk(OFS_CTRL, 32'h0000_0006, "start cleared");
         if (m != 0) begin
            apb(1'b1, OFS_STAT, 32'h0000_0007);
            repeat (2 * CL) @(posedge CLK);
            apb(1'b1, OFS_CTRL, 32'h0000_0000);
            k = 5 + ($unsigned($random(seed)) % 30);
            repeat (k) @(posedge CLK);
            BUS_ACTIVITY <= 1'b1;
            @(posedge CLK);
            BUS_ACTIVITY <= 1'b0;
            n = 0;
            while (XCVR_CTRL.speed_sel !== 1'b1 && n < 1000) begin
               @(negedge CLK);
               n++;
            end
            chk(n >= IC - 2 && n <= IC + 4, 1, "idle changeover");
            chk(XCVR_CTRL.term_sel, 1, "fs termination");
            @(posedge CLK);
            reset_req <= (m == 1);
            n = 0;
            while (INTERRUPT_OUT_N !== 1'b0 && n < 5000) begin
               @(negedge CLK);
               n++;
            end
            chk(n >= SAMPLE_CYC - 4 && n <= SAMPLE_CYC + 4, 1, "sample time");
            @(posedge CLK);
            rchk(OFS_STAT, (m == 1) ? 32'h0000_0001 : 32'h0000_0004, "hs sample");
         end
         $display("handshake test %0d done", m);
      end
      // Suspended device: handshake started at once on SE0
      reset_req <= 1'b1;
      apb(1'b1, OFS_CTRL, 32'h0000_0007);
      @(negedge CLK);
      chk(XCVR_CTRL.tx_valid, 1, "chirp from suspend");
      $display("suspend handshake test done");
      final_report();
   end
endmodule
